//--- hdl/pam_port_mux.sv
// Summary of operation
// - Alternate input of an output pin sees the output latch.
// - Hardware switches mux bus port direction during a bus access.
// - Mux port serves all four modes; address port only non-multiplexed.
// - Multiplexed: drive address, then float to read or drive write data.
// - Multiplexed 8-bit data: word access takes low then high byte cycle.
// - Non-multiplexed: address port drives address, mux port carries data.
// - Bus controller owns direction and latch input while bus enabled.
// - Disabling bus restores software direction register contents.
// - Non-multiplexed 8-bit mode keeps mux port upper half from I/O.
// - Capture line gets sampled input, or output latch when output.
// - Compare mode 1 toggles the compare port latch on trigger.
// - Compare mode 3 sets on match, clears on a trigger with timer overflow.
// - CPU write to compare latch wins over a coincident compare trigger.
// - Release request: sync, finish cycle, float bus, assert ack.
// - Ack held while request low; released and bus retaken after.
// - CPU stalls during grant only when it needs the external bus.
// - Grant acknowledge is active low and signals a free bus.
// - Device drives its own bus-need output toward the other master.
// - Arbitration enable takes over three pins, sticky until reset.
// - During grant the bus pins float as enabled; strobes weakly parked.
// - Direction zero disables the output buffer; one enables it.
// - Every pin level is sampled into its input latch each cycle.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module pam_port_mux (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [15:0] mux_bus_port_i,
  output logic [15:0]      mux_bus_port_o,
  output logic [15:0]      mux_bus_port_oe_n,
  input  wire logic [15:0] address_port_i,
  output logic [15:0]      address_port_o,
  output logic [15:0]      address_port_oe_n,
  input  wire logic [15:0] compare_port_i,
  output logic [15:0]      compare_port_o,
  output logic [15:0]      compare_port_oe_n,
  output logic             segment_float,
  output logic             upper_byte_float,
  output logic             write_strobe_float,
  output logic             strobes_parked,
  input  wire logic        ext_req,
  input  wire logic        ext_write,
  input  wire logic        ext_word,
  input  wire logic [15:0] ext_addr,
  input  wire logic [15:0] ext_wdata,
  output logic             ext_done,
  output logic [15:0]      ext_rdata,
  output logic             cpu_stall,
  output logic [15:0]      capture_compare_in,
  input  wire logic [15:0] cmp_trigger,
  input  wire logic [15:0] cmp_mode3,
  input  wire logic [15:0] cmp_overflow
);
  logic [15:0] mb_out_q, mb_dir_q, ad_out_q, ad_dir_q, cp_out_q, cp_dir_q;
  logic [15:0] mb_in_q, ad_in_q, cp_in_q;
  logic [5:0]  ctrl_q;
  logic        arb_lock_q;
  logic        rel_s1_q, rel_s2_q;
  logic [15:0] bus_out_q, rdata_q, lo_byte_q;
  logic        bus_drive_q;
  pam_pkg::pam_state_e st_q;
  logic        aw_q, w_q;
  logic [31:0] awaddr_q, wdata_q;
  logic [3:0]  wstrb_q;
  logic [31:0] rdata_d;
  logic        wr_go, bus_en, nonmux, bus8, arb_on, granted;
  pam_pkg::pam_mode_e mode;

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  assign bus_en  = ctrl_q[pam_pkg::CTRL_BUS_EN];
  assign mode    = pam_pkg::pam_mode_e'(ctrl_q[pam_pkg::CTRL_MODE_HI:
                                              pam_pkg::CTRL_MODE_LO]);
  assign nonmux  = bus_en && mode[1];
  assign bus8    = mode[0];
  assign arb_on  = ctrl_q[pam_pkg::CTRL_ARB_EN] || arb_lock_q;
  assign granted = st_q == pam_pkg::PAM_HELD;

  // AXI4-Lite slave; address and data may arrive in either order.
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_q && w_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pam_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q[31:2] <= pam_pkg::ADDR_STATUS[31:2])
                       ? pam_pkg::RESP_OKAY : pam_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    hit = a[31:2] == r[31:2];
  endfunction

  // Direction and control registers; directions survive bus use.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mb_dir_q <= pam_pkg::PORT_RST;
      ad_dir_q <= pam_pkg::PORT_RST;
      cp_dir_q <= pam_pkg::PORT_RST;
      ctrl_q   <= pam_pkg::CTRL_RST;
      mb_out_q <= pam_pkg::PORT_RST;
      ad_out_q <= pam_pkg::PORT_RST;
    end else if (wr_go) begin
      if (hit(awaddr_q, pam_pkg::ADDR_MB_DIR))
        mb_dir_q <= merge(mb_dir_q, wdata_q, wstrb_q);
      if (hit(awaddr_q, pam_pkg::ADDR_AD_DIR))
        ad_dir_q <= merge(ad_dir_q, wdata_q, wstrb_q);
      if (hit(awaddr_q, pam_pkg::ADDR_CP_DIR))
        cp_dir_q <= merge(cp_dir_q, wdata_q, wstrb_q);
      if (hit(awaddr_q, pam_pkg::ADDR_CTRL) && wstrb_q[0])
        ctrl_q <= wdata_q[5:0];
      // Latch writes while the bus owns a port are undefined; keep them.
      if (hit(awaddr_q, pam_pkg::ADDR_MB_OUT))
        mb_out_q <= merge(mb_out_q, wdata_q, wstrb_q);
      if (hit(awaddr_q, pam_pkg::ADDR_AD_OUT))
        ad_out_q <= merge(ad_out_q, wdata_q, wstrb_q);
    end
  end

  // Sticky arbitration ownership until reset.
  always_ff @(posedge aclk) begin
    if (!aresetn)
      arb_lock_q <= 1'b0;
    else if (ctrl_q[pam_pkg::CTRL_ARB_EN])
      arb_lock_q <= 1'b1;
  end

  // Compare port latch: CPU write wins, else per-pin compare action.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cp_out_q <= pam_pkg::PORT_RST;
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (wr_go && hit(awaddr_q, pam_pkg::ADDR_CP_OUT) &&
            wstrb_q[i/8]) begin
          cp_out_q[i] <= wdata_q[i];
        end else if (cmp_trigger[i]) begin
          if (!cmp_mode3[i])
            cp_out_q[i] <= !cp_out_q[i];
          else
            cp_out_q[i] <= !cmp_overflow[i];
        end
      end
    end
  end

  // Input latches sample every cycle in any direction.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mb_in_q <= pam_pkg::PORT_RST;
      ad_in_q <= pam_pkg::PORT_RST;
      cp_in_q <= pam_pkg::PORT_RST;
    end else begin
      mb_in_q <= mux_bus_port_i;
      ad_in_q <= address_port_i;
      cp_in_q <= compare_port_i;
    end
  end

  // An output pin reads back its own latch, so software can trigger.
  always_comb begin
    for (int i = 0; i < 16; i++)
      capture_compare_in[i] = cp_dir_q[i] ? cp_out_q[i]
                                          : cp_in_q[i];
  end

  // Release request synchroniser.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rel_s1_q <= 1'b1;
      rel_s2_q <= 1'b1;
    end else begin
      rel_s1_q <= compare_port_i[pam_pkg::PIN_RELEASE];
      rel_s2_q <= rel_s1_q;
    end
  end

  // External bus sequencer and arbitration.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= pam_pkg::PAM_IDLE;
      bus_out_q <= 16'h0000;
      bus_drive_q <= 1'b0;
      rdata_q <= 16'h0000;
      lo_byte_q <= 16'h0000;
      ext_done <= 1'b0;
    end else begin
      ext_done <= 1'b0;
      case (st_q)
        pam_pkg::PAM_IDLE: begin
          if (arb_on && !rel_s2_q) begin
            st_q <= pam_pkg::PAM_HELD;
            bus_drive_q <= 1'b0;
          end else if (bus_en && ext_req && !ext_done) begin
            st_q <= pam_pkg::PAM_ADDR;
            bus_out_q <= ext_addr;
            bus_drive_q <= !nonmux;
          end
        end
        pam_pkg::PAM_ADDR: begin
          st_q <= pam_pkg::PAM_DATA;
          bus_out_q <= (bus8 && !nonmux) ? {8'h00, ext_wdata[7:0]}
                                         : ext_wdata;
          bus_drive_q <= ext_write;
        end
        pam_pkg::PAM_DATA: begin
          // Pins are taken directly: the input latch still holds the
          // address phase at this edge.
          lo_byte_q <= {8'h00, mux_bus_port_i[7:0]};
          if (bus8 && ext_word) begin
            st_q <= pam_pkg::PAM_DATA2;
            bus_out_q <= {8'h00, ext_wdata[15:8]};
          end else begin
            st_q <= pam_pkg::PAM_IDLE;
            rdata_q <= bus8 ? {8'h00, mux_bus_port_i[7:0]}
                            : mux_bus_port_i;
            ext_done <= 1'b1;
            bus_drive_q <= 1'b0;
          end
        end
        pam_pkg::PAM_DATA2: begin
          st_q <= pam_pkg::PAM_IDLE;
          rdata_q <= {mux_bus_port_i[7:0], lo_byte_q[7:0]};
          ext_done <= 1'b1;
          bus_drive_q <= 1'b0;
        end
        pam_pkg::PAM_HELD: begin
          if (rel_s2_q)
            st_q <= pam_pkg::PAM_IDLE;
        end
        default: st_q <= pam_pkg::PAM_IDLE;
      endcase
    end
  end

  assign ext_rdata = rdata_q;
  assign cpu_stall = granted && ext_req;

  // Pin drivers; oe_n low means driven.
  always_comb begin
    mux_bus_port_o    = mb_out_q;
    mux_bus_port_oe_n = ~mb_dir_q;
    address_port_o    = ad_out_q;
    address_port_oe_n = ~ad_dir_q;
    compare_port_o    = cp_out_q;
    compare_port_oe_n = ~cp_dir_q;
    if (bus_en) begin
      mux_bus_port_o    = bus_out_q;
      mux_bus_port_oe_n = {16{!bus_drive_q || granted}};
      if (mode == pam_pkg::PAM_NONMUX8)
        mux_bus_port_oe_n[15:8] = 8'hff;
      if (nonmux) begin
        address_port_o    = ext_addr;
        address_port_oe_n = {16{granted}};
      end
    end
    if (arb_on) begin
      compare_port_oe_n[pam_pkg::PIN_RELEASE] = 1'b1;
      compare_port_o[pam_pkg::PIN_ACK]  = !granted;
      compare_port_oe_n[pam_pkg::PIN_ACK]  = 1'b0;
      compare_port_o[pam_pkg::PIN_NEED] = !(bus_en && ext_req);
      compare_port_oe_n[pam_pkg::PIN_NEED] = 1'b0;
    end
  end
  assign segment_float      = granted && bus_en &&
                              ctrl_q[pam_pkg::CTRL_SEG_EN];
  assign upper_byte_float   = granted && ctrl_q[pam_pkg::CTRL_UBS_EN];
  assign write_strobe_float = granted;
  assign strobes_parked     = granted;

  // Register read path.
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (s_axi_araddr[7:2])
      pam_pkg::ADDR_MB_OUT[7:2]: rdata_d[15:0] = mb_out_q;
      pam_pkg::ADDR_MB_DIR[7:2]: rdata_d[15:0] = mb_dir_q;
      pam_pkg::ADDR_AD_OUT[7:2]: rdata_d[15:0] = ad_out_q;
      pam_pkg::ADDR_AD_DIR[7:2]: rdata_d[15:0] = ad_dir_q;
      pam_pkg::ADDR_CP_OUT[7:2]: rdata_d[15:0] = cp_out_q;
      pam_pkg::ADDR_CP_DIR[7:2]: rdata_d[15:0] = cp_dir_q;
      pam_pkg::ADDR_MB_IN[7:2]:  rdata_d[15:0] = mb_in_q;
      pam_pkg::ADDR_AD_IN[7:2]:  rdata_d[15:0] = ad_in_q;
      pam_pkg::ADDR_CP_IN[7:2]:  rdata_d[15:0] = cp_in_q;
      pam_pkg::ADDR_CTRL[7:2]:   rdata_d[5:0]  = ctrl_q;
      pam_pkg::ADDR_STATUS[7:2]: rdata_d[3:0]  = {arb_lock_q, granted,
                                                  st_q != pam_pkg::PAM_IDLE,
                                                  !rel_s2_q};
      default:                   rdata_d = 32'h0000_0000;
    endcase
    if (s_axi_araddr[31:8] != 24'h00_0000)
      rdata_d = 32'h0000_0000;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pam_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= (s_axi_araddr[31:2] <= pam_pkg::ADDR_STATUS[31:2])
                     ? pam_pkg::RESP_OKAY : pam_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  a_grant_after_sync: assert property (@(posedge aclk) disable iff (!aresetn)
    (arb_on && st_q == pam_pkg::PAM_IDLE && !rel_s2_q) |=> granted)
    else $error("grant not taken after release request");
  a_ack_pin_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (arb_on && granted) |-> !compare_port_o[pam_pkg::PIN_ACK])
    else $error("ack not low while granted");
  a_release_ends: assert property (@(posedge aclk) disable iff (!aresetn)
    (granted && rel_s2_q) |=> !granted)
    else $error("grant held after release");
  a_arb_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    arb_lock_q |=> arb_lock_q)
    else $error("arbitration lock dropped");
  a_cpu_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && hit(awaddr_q, pam_pkg::ADDR_CP_OUT) && wstrb_q[0])
    |=> cp_out_q[0] == $past(wdata_q[0]))
    else $error("compare trigger beat cpu write");
  a_toggle_mode1: assert property (@(posedge aclk) disable iff (!aresetn)
    (cmp_trigger[1] && !cmp_mode3[1] && !wr_go)
    |=> cp_out_q[1] != $past(cp_out_q[1]))
    else $error("mode 1 did not toggle");
  a_capture_loop: assert property (@(posedge aclk) disable iff (!aresetn)
    cp_dir_q[2] |-> capture_compare_in[2] == cp_out_q[2])
    else $error("capture not from latch");
  a_sync_delay: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(compare_port_i[pam_pkg::PIN_RELEASE]) ##1
    !compare_port_i[pam_pkg::PIN_RELEASE] |=> !rel_s2_q)
    else $error("sync latency wrong");
endmodule // pam_port_mux
`default_nettype wire

//--- hdl/pam_pkg.sv
`default_nettype none
package pam_pkg;
  localparam int unsigned PORT_W = 16;
  localparam logic [31:0] ADDR_MB_OUT  = 32'h0000_0000;
  localparam logic [31:0] ADDR_MB_DIR  = 32'h0000_0004;
  localparam logic [31:0] ADDR_AD_OUT  = 32'h0000_0008;
  localparam logic [31:0] ADDR_AD_DIR  = 32'h0000_000c;
  localparam logic [31:0] ADDR_CP_OUT  = 32'h0000_0010;
  localparam logic [31:0] ADDR_CP_DIR  = 32'h0000_0014;
  localparam logic [31:0] ADDR_MB_IN   = 32'h0000_0018;
  localparam logic [31:0] ADDR_AD_IN   = 32'h0000_001c;
  localparam logic [31:0] ADDR_CP_IN   = 32'h0000_0020;
  localparam logic [31:0] ADDR_CTRL    = 32'h0000_0024;
  localparam logic [31:0] ADDR_STATUS  = 32'h0000_0028;
  localparam logic [15:0] PORT_RST     = 16'h0000;
  localparam int unsigned CTRL_BUS_EN  = 0;
  localparam int unsigned CTRL_MODE_LO = 1;
  localparam int unsigned CTRL_MODE_HI = 2;
  localparam int unsigned CTRL_ARB_EN  = 3;
  localparam int unsigned CTRL_SEG_EN  = 4;
  localparam int unsigned CTRL_UBS_EN  = 5;
  localparam logic [5:0]  CTRL_RST     = 6'h00;
  localparam int unsigned PIN_RELEASE  = 15;
  localparam int unsigned PIN_ACK      = 14;
  localparam int unsigned PIN_NEED     = 13;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  // Bus modes: mux/non-mux, 16-bit/8-bit data.
  typedef enum logic [1:0] {
    PAM_MUX16    = 2'b00,
    PAM_MUX8     = 2'b01,
    PAM_NONMUX16 = 2'b10,
    PAM_NONMUX8  = 2'b11
  } pam_mode_e;
  typedef enum logic [2:0] {
    PAM_IDLE  = 3'b000,
    PAM_ADDR  = 3'b001,
    PAM_DATA  = 3'b010,
    PAM_DATA2 = 3'b011,
    PAM_HELD  = 3'b100
  } pam_state_e;
endpackage
`default_nettype wire

//--- verification/pam_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module pam_far_model (
  input  wire logic [15:0] mb_o,
  input  wire logic [15:0] mb_oe_n,
  input  wire logic [15:0] ad_o,
  input  wire logic [15:0] ad_oe_n,
  input  wire logic [15:0] cp_o,
  input  wire logic [15:0] cp_oe_n,
  input  wire logic [15:0] mem_data,
  input  wire logic [15:0] ad_pins,
  input  wire logic [15:0] cp_pins,
  input  wire logic        release_n,
  output logic      [15:0] mb_i,
  output logic      [15:0] ad_i,
  output logic      [15:0] cp_i
);
  logic [15:0] cp_far;
  // The memory answers on every line that the device has let go.
  assign mb_i = (mb_o & ~mb_oe_n) | (mem_data & mb_oe_n);
  assign ad_i = (ad_o & ~ad_oe_n) | (ad_pins & ad_oe_n);
  // Release stays low while the other master uses the bus.
  assign cp_far = {release_n, cp_pins[14:0]};
  assign cp_i = (cp_o & ~cp_oe_n) | (cp_far & cp_oe_n);
endmodule // pam_far_model
`default_nettype wire

//--- verification/port_alternate_function_mux_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module port_alternate_function_mux_tb_top;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, ext_req;
  logic        seg_f, ubs_f, wr_f, park, ext_write, ext_word, ext_done;
  logic        stall, release_n;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [15:0] mb_i, mb_o, mb_oe_n, ad_i, ad_o, ad_oe_n, cp_i, cp_o;
  logic [15:0] cp_oe_n, ext_addr, ext_wdata, ext_rdata, cc_in, trig;
  logic [15:0] mode3, ovf, mem_data, ad_pins, cp_pins;
  int          mismatches, cmp_count;
  int          cycles = 0;
  pam_port_mux DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .mux_bus_port_i(mb_i), .mux_bus_port_o(mb_o),
    .mux_bus_port_oe_n(mb_oe_n), .address_port_i(ad_i),
    .address_port_o(ad_o), .address_port_oe_n(ad_oe_n),
    .compare_port_i(cp_i), .compare_port_o(cp_o),
    .compare_port_oe_n(cp_oe_n), .segment_float(seg_f),
    .upper_byte_float(ubs_f), .write_strobe_float(wr_f),
    .strobes_parked(park), .ext_req(ext_req), .ext_write(ext_write),
    .ext_word(ext_word), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ext_done(ext_done), .ext_rdata(ext_rdata), .cpu_stall(stall),
    .capture_compare_in(cc_in), .cmp_trigger(trig), .cmp_mode3(mode3),
    .cmp_overflow(ovf));
  pam_far_model far (.mb_o(mb_o), .mb_oe_n(mb_oe_n), .ad_o(ad_o),
    .ad_oe_n(ad_oe_n), .cp_o(cp_o), .cp_oe_n(cp_oe_n), .mem_data(mem_data),
    .ad_pins(ad_pins), .cp_pins(cp_pins), .release_n(release_n),
    .mb_i(mb_i), .ad_i(ad_i), .cp_i(cp_i));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Every bus task is entered just after a rising edge.
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic       ah, wh, bh;
    logic [1:0] br;
    bh = 1'b0;
    br = 2'h3;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bh) begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      br = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
    chk(32'(br), 32'(pam_pkg::RESP_OKAY));
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ah, rh;
    rh = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rh) begin
      @(negedge aclk);
      ah = arvalid && arready;
      rh = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
    end
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e);
  endtask
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    chk(32'(mb_oe_n & ad_oe_n & cp_oe_n), 32'hffff);
    // The idle release request line reads high on the compare port.
    for (int i = 0; i < 10; i++)
      rdchk(32'(i * 4), (i == 8) ? 32'h8000 : 32'h0);
    rd(32'h0000_002c, d, r);
    chk(32'(r), 32'(pam_pkg::RESP_SLVERR));
  endtask
  task automatic t_gpio();
    wr(pam_pkg::ADDR_AD_OUT, 32'h3c5a);
    wr(pam_pkg::ADDR_AD_DIR, 32'hffff);
    chk(32'({ad_o, ad_oe_n}), 32'h3c5a_0000);
    ad_pins <= 16'ha5c3;
    wr(pam_pkg::ADDR_AD_DIR, 32'h0);
    chk(32'(ad_oe_n), 32'hffff);
    rdchk(pam_pkg::ADDR_AD_IN, 32'ha5c3);
    wr(pam_pkg::ADDR_AD_DIR, 32'hffff);
    rdchk(pam_pkg::ADDR_AD_IN, 32'h3c5a);
  endtask
  task automatic t_capture();
    cp_pins <= 16'h00f0;
    repeat (3) @(posedge aclk);
    chk(32'(cc_in), 32'h80f0);
    wr(pam_pkg::ADDR_CP_OUT, 32'h1234);
    wr(pam_pkg::ADDR_CP_DIR, 32'hffff);
    chk(32'(cc_in), 32'h1234);
  endtask
  task automatic pulse(input logic [15:0] m, input logic [15:0] e);
    trig <= m;
    @(posedge aclk);
    trig <= 16'h0000;
    @(posedge aclk);
    chk(32'(cp_o), 32'(e));
  endtask
  task automatic t_compare();
    pulse(16'h0001, 16'h1235);
    pulse(16'h0001, 16'h1234);
    mode3 <= 16'h0002;
    pulse(16'h0002, 16'h1236);
    ovf <= 16'h0002;
    pulse(16'h0002, 16'h1234);
    mode3 <= 16'h0000;
    // The trigger lands on the second edge, the one that applies the write.
    fork
      begin
        @(posedge aclk);
        trig <= 16'h0001;
        @(posedge aclk);
        trig <= 16'h0000;
      end
    join_none
    wr(pam_pkg::ADDR_CP_OUT, 32'h1234);
    chk(32'(cp_o), 32'h1234);
    pulse(16'h0002, 16'h1236);
  endtask
  // One external access; counts negedges until the done pulse.
  // Latches of a bus-owned port are never written meanwhile.
  task automatic ext(input logic [5:0] ctl, input logic w, input int ne);
    int   n;
    logic dn;
    n = 0;
    dn = 1'b0;
    wr(pam_pkg::ADDR_CTRL, 32'(ctl));
    if (ctl == 6'h07) chk(32'(mb_oe_n[15:8]), 32'hff);
    {ext_req, ext_write, ext_word} <= {1'b1, w, 1'b1};
    do begin
      @(negedge aclk);
      n++;
      if (n == 2 && ctl[2]) chk(32'({ad_o, ad_oe_n}), 32'h4a21_0000);
      if (n == 2 && !ctl[2]) chk(32'({mb_o, mb_oe_n}), 32'h4a21_0000);
      if (n == 2 && !ctl[2]) chk(32'(ad_o), 32'h3c5a);
      if (n == 3 && !w) chk(32'(mb_oe_n), 32'hffff);
      if (n == 3 && w && !ctl[1]) chk(32'(mb_o), 32'h9e37);
      if (n == 3 && w && ctl == 6'h07) chk(32'(mb_oe_n), 32'hff00);
      dn = ext_done;
      @(posedge aclk);
    end while (dn !== 1'b1 && n < 20);
    chk(32'(n), 32'(ne));
    if (!w && !ctl[1]) chk(32'(ext_rdata), 32'h6b18);
    ext_req <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask
  task automatic t_arb();
    int n;
    wr(pam_pkg::ADDR_CTRL, 32'h39);
    chk(32'({cp_oe_n[15:13], cp_o[14], stall}), 32'h12);
    release_n <= 1'b0;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (cp_o[14] !== 1'b0 && n < 10);
    @(posedge aclk);
    chk(32'(n < 10), 32'h1);
    chk(32'({mb_oe_n, seg_f, ubs_f, wr_f, park}), 32'hf_ffff);
    chk(32'(ad_oe_n), 32'h0);
    ext_req <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(32'({stall, ext_done, cp_o[13]}), 32'h4);
    release_n <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (ext_done !== 1'b1 && n < 20);
    @(posedge aclk);
    chk(32'({n < 20, cp_o[14]}), 32'h3);
    ext_req <= 1'b0;
    repeat (4) @(posedge aclk);
    wr(pam_pkg::ADDR_CTRL, 32'h01);
    chk(32'(cp_oe_n[15:13]), 32'h4);
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {ext_req, ext_write, ext_word} = 3'h0;
    {awaddr, wdata, araddr} = {32'h0, 32'h0, 32'h0};
    {trig, mode3, ovf, ad_pins, cp_pins} = {16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    {ext_addr, ext_wdata, mem_data} = {16'h4a21, 16'h9e37, 16'h0000};
    wstrb = 4'hf;
    release_n = 1'b1;
    {mismatches, cmp_count} = {32'h0, 32'h0};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_gpio();
    t_capture();
    t_compare();
    mem_data <= 16'h6b18;
    wr(pam_pkg::ADDR_MB_DIR, 32'hff00);
    ext(6'h01, 1'b0, 4);
    ext(6'h01, 1'b1, 4);
    ext(6'h03, 1'b0, 5);
    ext(6'h05, 1'b0, 4);
    ext(6'h05, 1'b1, 4);
    ext(6'h07, 1'b1, 5);
    wr(pam_pkg::ADDR_CTRL, 32'h0);
    chk(32'(mb_oe_n), 32'h00ff);
    t_arb();
    finish_test();
  end
endmodule // port_alternate_function_mux_tb_top
`default_nettype wire
